// ===== serial_queue_sequencer_control.sv
`timescale 1ns/100ps
module serial_queue_sequencer_control (
  input wire logic clock,
  input wire logic resetn,
  input wire logic link_clock,
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire logic [11:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_ready,
  output logic bus_error,
  output logic irq,
  output logic transfer_enable,
  output logic [3:0] select,
  output logic serial_clock,
  output logic serial_out,
  input wire logic serial_in
);
  import serial_queue_pkg::*;

  logic transfer_enable_bit;
  logic [14:0] delay_fields;
  logic halt, wraparound_enable, wrap_destination_select, select_idle_level;
  logic [3:0] end_ptr, done_ptr, start_ptr, ptr;
  logic coll_err_en, abort_err_en, lockout;
  logic coll_int_en, abort_int_en, fin_int_en;
  logic coll_flag, abort_flag, fin_flag;
  logic [5:0] addr;
  logic [15:0] tx_ram [RAM_ENTRIES];
  logic [15:0] rx_ram [RAM_ENTRIES];
  logic [7:0] cmd_ram [RAM_ENTRIES];
  seq_state_t state;
  link_cmd_t link_cmd;
  logic req_toggle, ack_toggle, ack_meta, ack_sync, ack_seen;
  logic [15:0] link_rx;
  logic read_wait;

  logic accept, wr, rd;
  logic hit_delay, hit_wrap, hit_flags, hit_addr, hit_data;
  logic busy, running_entry, coll_event, coll_error;
  logic spe_clear_try, abort_error, abort_event, port_write;
  logic at_end, completing, seq_clear, fin_event;
  logic [15:0] reg_read, ram_read;

  // a request is taken only when no answer is pending, so a held valid is not re-taken in its answer cycle
  assign accept = bus_valid && !read_wait && !bus_ready;
  assign wr = accept && bus_write;
  assign rd = accept && !bus_write;
  assign hit_delay = bus_addr == DELAY_ENABLE_OFFSET;
  assign hit_wrap = bus_addr == WRAP_OFFSET;
  assign hit_flags = bus_addr == FLAGS_OFFSET;
  assign hit_addr = bus_addr == ADDRESS_OFFSET;
  assign hit_data = bus_addr == DATA_PORT_OFFSET;

  assign busy = state != SEQ_IDLE;
  assign running_entry = busy && addr[5:4] == CMD_SECTION && addr[3:0] == ptr;
  assign coll_event = wr && hit_data && running_entry;
  assign coll_error = coll_event && coll_err_en;
  assign spe_clear_try = wr && hit_delay && !bus_wdata[ENABLE_BIT] && transfer_enable_bit;
  assign abort_error = spe_clear_try && busy && abort_err_en;
  assign abort_event = spe_clear_try && !lockout && !abort_error;
  assign port_write = wr && hit_data && !coll_error;

  assign at_end = ptr == end_ptr;
  assign completing = state == SEQ_DONE && transfer_enable_bit;
  assign seq_clear = completing && (halt || (at_end && !wraparound_enable));
  assign fin_event = completing && (halt || at_end);

  assign irq = (coll_flag && coll_int_en) || (abort_flag && abort_int_en)
      || (fin_flag && fin_int_en);
  assign transfer_enable = transfer_enable_bit;

  always_comb begin
    case (addr[5:4])
      TX_SECTION: ram_read = tx_ram[addr[3:0]];
      RX_SECTION: ram_read = rx_ram[addr[3:0]];
      CMD_SECTION: ram_read = {cmd_ram[addr[3:0]], 8'h00};
      default: ram_read = 16'h0000;
    endcase
  end

  always_comb begin
    reg_read = 16'h0000;
    if (hit_delay) begin
      reg_read = {transfer_enable_bit, delay_fields};
    end else if (hit_wrap) begin
      reg_read = {halt, wraparound_enable, wrap_destination_select, select_idle_level, end_ptr, done_ptr, start_ptr};
    end else if (hit_flags) begin
      reg_read[COLL_ERR_EN_BIT] = coll_err_en;
      reg_read[ABORT_ERR_EN_BIT] = abort_err_en;
      reg_read[LOCKOUT_BIT] = lockout;
      reg_read[COLL_INT_EN_BIT] = coll_int_en;
      reg_read[ABORT_INT_EN_BIT] = abort_int_en;
      reg_read[FIN_INT_EN_BIT] = fin_int_en;
      reg_read[COLL_FLAG_BIT] = coll_flag;
      reg_read[ABORT_FLAG_BIT] = abort_flag;
      reg_read[FIN_FLAG_BIT] = fin_flag;
    end else if (hit_addr) begin
      reg_read = {10'h000, addr};
    end
  end

  // bus answer: one cycle after acceptance, data-port reads one cycle later
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_ready <= 1'b0;
      bus_error <= 1'b0;
      bus_rdata <= 16'h0000;
      read_wait <= 1'b0;
    end else if (rd && hit_data) begin
      read_wait <= 1'b1;
      bus_ready <= 1'b0;
      bus_error <= 1'b0;
    end else if (read_wait) begin
      read_wait <= 1'b0;
      bus_ready <= 1'b1;
      bus_error <= 1'b0;
      bus_rdata <= ram_read;
    end else if (accept) begin
      bus_ready <= 1'b1;
      bus_error <= coll_error || abort_error;
      bus_rdata <= bus_write ? 16'h0000 : reg_read;
    end else begin
      bus_ready <= 1'b0;
      bus_error <= 1'b0;
    end
  end

  // no per-section wrap: the pointer runs on through the 6-bit space
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addr <= ADDRESS_RESET;
    end else if (wr && hit_addr) begin
      addr <= bus_wdata[5:0];
    end else if (port_write || read_wait) begin
      addr <= addr + 6'h01;
    end
  end

  // the sequencer write of a received word wins over a cpu write to it
  always_ff @(posedge clock) begin
    if (port_write) begin
      case (addr[5:4])
        TX_SECTION: tx_ram[addr[3:0]] <= bus_wdata;
        RX_SECTION: rx_ram[addr[3:0]] <= bus_wdata;
        CMD_SECTION: cmd_ram[addr[3:0]] <= bus_wdata[15:8];
        default: ;
      endcase
    end
    if (state == SEQ_DONE) begin
      rx_ram[ptr] <= link_rx;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      transfer_enable_bit <= DELAY_ENABLE_RESET[ENABLE_BIT];
      delay_fields <= DELAY_ENABLE_RESET[14:0];
    end else if (wr && hit_delay && !abort_error) begin
      delay_fields <= bus_wdata[14:0];
      if (bus_wdata[ENABLE_BIT]) begin
        transfer_enable_bit <= 1'b1;
      end else if (abort_event) begin
        transfer_enable_bit <= 1'b0;
      end else if (seq_clear) begin
        transfer_enable_bit <= 1'b0;
      end
    end else if (seq_clear) begin
      transfer_enable_bit <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {halt, wraparound_enable, wrap_destination_select, select_idle_level} <= WRAP_RESET[15:12];
      end_ptr <= WRAP_RESET[11:8];
      start_ptr <= WRAP_RESET[3:0];
    end else if (wr && hit_wrap) begin
      halt <= bus_wdata[HALT_BIT];
      wraparound_enable <= bus_wdata[WRAP_ENABLE_BIT];
      wrap_destination_select <= bus_wdata[WRAP_DEST_BIT];
      select_idle_level <= bus_wdata[IDLE_LEVEL_BIT];
      end_ptr <= bus_wdata[END_PTR_LSB +: 4];
      start_ptr <= bus_wdata[START_PTR_LSB +: 4];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {coll_err_en, abort_err_en} <= FLAGS_RESET[15:14];
      {lockout, coll_int_en, abort_int_en} <= FLAGS_RESET[12:10];
      fin_int_en <= FLAGS_RESET[FIN_INT_EN_BIT];
    end else if (wr && hit_flags) begin
      coll_err_en <= bus_wdata[COLL_ERR_EN_BIT];
      abort_err_en <= bus_wdata[ABORT_ERR_EN_BIT];
      lockout <= bus_wdata[LOCKOUT_BIT];
      coll_int_en <= bus_wdata[COLL_INT_EN_BIT];
      abort_int_en <= bus_wdata[ABORT_INT_EN_BIT];
      fin_int_en <= bus_wdata[FIN_INT_EN_BIT];
    end
  end

  // a new event in the clearing cycle keeps its flag set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      coll_flag <= FLAGS_RESET[COLL_FLAG_BIT];
      abort_flag <= FLAGS_RESET[ABORT_FLAG_BIT];
      fin_flag <= FLAGS_RESET[FIN_FLAG_BIT];
    end else begin
      coll_flag <= (coll_flag && !(wr && hit_flags && bus_wdata[COLL_FLAG_BIT]))
          || coll_event;
      abort_flag <= (abort_flag && !(wr && hit_flags && bus_wdata[ABORT_FLAG_BIT]))
          || abort_event;
      fin_flag <= (fin_flag && !(wr && hit_flags && bus_wdata[FIN_FLAG_BIT]))
          || fin_event;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      ack_meta <= ack_toggle;
      ack_sync <= ack_meta;
    end
  end

  // an aborted command still runs to its end on the link before the queue stops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= SEQ_IDLE;
      ptr <= 4'h0;
      done_ptr <= WRAP_RESET[7:4];
      link_cmd <= '0;
      req_toggle <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      case (state)
        SEQ_IDLE: begin
          if (transfer_enable_bit && !halt) begin
            ptr <= start_ptr;
            state <= SEQ_ISSUE;
          end
        end
        SEQ_ISSUE: begin
          link_cmd <= '{select: cmd_ram[ptr][3:0], data: tx_ram[ptr]};
          req_toggle <= ~req_toggle;
          state <= SEQ_WAIT;
        end
        SEQ_WAIT: begin
          if (ack_sync != ack_seen) begin
            ack_seen <= ack_sync;
            state <= SEQ_DONE;
          end
        end
        SEQ_DONE: begin
          done_ptr <= ptr;
          if (!transfer_enable_bit || halt) begin
            state <= SEQ_IDLE;
          end else if (at_end) begin
            if (wraparound_enable) begin
              ptr <= wrap_destination_select ? start_ptr : 4'h0;
              state <= SEQ_ISSUE;
            end else begin
              state <= SEQ_IDLE;
            end
          end else begin
            ptr <= ptr + 4'h1;
            state <= SEQ_ISSUE;
          end
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end

  serial_link_shifter link_end (
    .link_clock(link_clock),
    .resetn(resetn),
    .req_toggle(req_toggle),
    .cmd(link_cmd),
    .idle_level(select_idle_level),
    .ack_toggle(ack_toggle),
    .rx_data(link_rx),
    .select(select),
    .serial_clock(serial_clock),
    .serial_out(serial_out),
    .serial_in(serial_in)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_halt_stops: assert property (state == SEQ_DONE && halt |=> state == SEQ_IDLE)
    else $error("halt did not stop the queue");
  a_end_stops: assert property (completing && at_end && !wraparound_enable && !halt
      |=> !transfer_enable_bit && state == SEQ_IDLE)
    else $error("queue ran past end entry");
  a_wrap_target: assert property (completing && at_end && wraparound_enable && !halt
      |=> state == SEQ_ISSUE && ptr == ($past(wrap_destination_select) ? $past(start_ptr) : 4'h0))
    else $error("wrap went to wrong entry");
  a_start_entry: assert property (state == SEQ_IDLE && transfer_enable_bit && !halt
      |=> ptr == $past(start_ptr))
    else $error("queue did not start at start pointer");
  a_done_pointer: assert property (state == SEQ_DONE |=> done_ptr == $past(ptr))
    else $error("completed pointer not updated");
  a_finish_flag: assert property (fin_event |=> fin_flag [*2] or fin_flag ##1 1'b1)
    else $error("finished flag not set");
  a_coll_error: assert property (coll_event && coll_err_en |=> bus_ready && bus_error)
    else $error("collision write did not error");
  a_abort_lock: assert property (wr && hit_delay && lockout && transfer_enable_bit && !seq_clear
      |=> transfer_enable_bit)
    else $error("lock-out failed to hold enable");
  a_read_wait: assert property (rd && hit_data |=> !bus_ready ##1 bus_ready
      && addr == $past(addr, 2) + 6'h01)
    else $error("data read wait state or increment wrong");
  a_irq_gate: assert property (fin_flag && fin_int_en |-> irq)
    else $error("irq missing for enabled flag");
endmodule : serial_queue_sequencer_control

// ===== serial_queue_pkg.sv
package serial_queue_pkg;
  // register byte offsets on the internal bus
  localparam logic [11:0] DELAY_ENABLE_OFFSET = 12'h344;
  localparam logic [11:0] WRAP_OFFSET = 12'h348;
  localparam logic [11:0] FLAGS_OFFSET = 12'h34C;
  localparam logic [11:0] ADDRESS_OFFSET = 12'h350;
  localparam logic [11:0] DATA_PORT_OFFSET = 12'h354;

  localparam logic [15:0] DELAY_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] WRAP_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [5:0] ADDRESS_RESET = 6'h00;

  // delay_and_enable_register
  localparam int ENABLE_BIT = 15;
  // queue_wrap_control fields
  localparam int HALT_BIT = 15;
  localparam int WRAP_ENABLE_BIT = 14;
  localparam int WRAP_DEST_BIT = 13;
  localparam int IDLE_LEVEL_BIT = 12;
  localparam int END_PTR_LSB = 8;
  localparam int DONE_PTR_LSB = 4;
  localparam int START_PTR_LSB = 0;
  // interrupt_flags_and_enables fields
  localparam int COLL_ERR_EN_BIT = 15;
  localparam int ABORT_ERR_EN_BIT = 14;
  localparam int LOCKOUT_BIT = 12;
  localparam int COLL_INT_EN_BIT = 11;
  localparam int ABORT_INT_EN_BIT = 10;
  localparam int FIN_INT_EN_BIT = 8;
  localparam int COLL_FLAG_BIT = 3;
  localparam int ABORT_FLAG_BIT = 2;
  localparam int FIN_FLAG_BIT = 0;

  // ram sections selected by address bits 5:4
  localparam logic [1:0] TX_SECTION = 2'h0;
  localparam logic [1:0] RX_SECTION = 2'h1;
  localparam logic [1:0] CMD_SECTION = 2'h2;
  localparam int RAM_ENTRIES = 16;

  typedef struct packed {
    logic [3:0] select;
    logic [15:0] data;
  } link_cmd_t;

  typedef enum {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT, SEQ_DONE} seq_state_t;
endpackage : serial_queue_pkg

// ===== serial_link_shifter.sv
`timescale 1ns/100ps
module serial_link_shifter (
  input wire logic link_clock,
  input wire logic resetn,
  input wire logic req_toggle,
  input wire serial_queue_pkg::link_cmd_t cmd,
  input wire logic idle_level,
  output logic ack_toggle,
  output logic [15:0] rx_data,
  output logic [3:0] select,
  output logic serial_clock,
  output logic serial_out,
  input wire logic serial_in
);
  import serial_queue_pkg::*;

  logic req_meta, req_sync, req_seen;
  logic idle_meta, idle_sync;
  logic in_meta, in_sync;
  logic active;
  logic [15:0] shift;
  logic [4:0] bits_left;

  always_ff @(posedge link_clock or negedge resetn) begin
    if (!resetn) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      idle_meta <= 1'b0;
      idle_sync <= 1'b0;
      in_meta <= 1'b0;
      in_sync <= 1'b0;
    end else begin
      req_meta <= req_toggle;
      req_sync <= req_meta;
      idle_meta <= idle_level;
      idle_sync <= idle_meta;
      in_meta <= serial_in;
      in_sync <= in_meta;
    end
  end

  // command word is held stable by the sequencer until the ack toggles back
  always_ff @(posedge link_clock or negedge resetn) begin
    if (!resetn) begin
      req_seen <= 1'b0;
      active <= 1'b0;
      shift <= 16'h0000;
      bits_left <= 5'h00;
      serial_clock <= 1'b0;
      ack_toggle <= 1'b0;
      rx_data <= 16'h0000;
    end else if (!active) begin
      serial_clock <= 1'b0;
      if (req_sync != req_seen) begin
        req_seen <= req_sync;
        active <= 1'b1;
        shift <= cmd.data;
        bits_left <= 5'h10;
      end
    end else if (!serial_clock) begin
      serial_clock <= 1'b1;
    end else begin
      serial_clock <= 1'b0;
      shift <= {shift[14:0], in_sync};
      bits_left <= bits_left - 5'h01;
      if (bits_left == 5'h01) begin
        active <= 1'b0;
        rx_data <= {shift[14:0], in_sync};
        ack_toggle <= ~ack_toggle;
      end
    end
  end

  always_ff @(posedge link_clock or negedge resetn) begin
    if (!resetn) begin
      select <= 4'hF;
      serial_out <= 1'b0;
    end else begin
      select <= active ? cmd.select : {4{idle_sync}};
      serial_out <= active ? shift[15] : 1'b0;
    end
  end

  a_select_idle: assert property (@(posedge link_clock) disable iff (!resetn)
      !active ##1 !active |-> select == {4{$past(idle_sync)}})
    else $error("select lines not at idle level");
endmodule : serial_link_shifter

// ===== serial_peripheral_model.sv
`timescale 1ns/100ps
module serial_peripheral_model #(
  parameter logic [15:0] RESP = 16'hC3A5
) (
  input wire logic [3:0] select,
  input wire logic idle_level,
  input wire logic serial_clock,
  input wire logic serial_out,
  output logic serial_in,
  output logic [15:0] rx_word,
  output logic [3:0] seen_select
);
  logic [15:0] shift;
  logic [3:0] idx;
  logic active;
  assign active = (select !== {4{idle_level}});
  initial begin
    serial_in = 1'b0;
    shift = 16'h0000;
    idx = 4'h0;
  end
  // serial_out moves with the rising serial clock, so it is taken on the falling one
  always @(negedge serial_clock) begin
    if (active) begin
      shift <= {shift[14:0], serial_out};
      seen_select <= select;
      idx <= idx + 4'h1;
      serial_in <= RESP[4'hE - idx];
    end
  end
  // a released line must not keep showing its last bit
  always @(active) begin
    if (active) begin
      idx = 4'h0;
      serial_in = RESP[15];
    end else begin
      rx_word = shift;
      serial_in = ~serial_in;
    end
  end
endmodule : serial_peripheral_model

// ===== serial_queue_sequencer_control_tb_top.sv
`timescale 1ns/100ps
module serial_queue_sequencer_control_tb_top;
  import serial_queue_pkg::*;
  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic resetn = 1'b0;
  logic bus_valid = 1'b0;
  logic bus_write = 1'b0;
  logic [11:0] bus_addr = 12'h000;
  logic [15:0] bus_wdata = 16'h0000;
  logic [15:0] bus_rdata;
  logic bus_ready, bus_error, irq, transfer_enable, serial_clock, serial_out, serial_in;
  logic [3:0] select, seen_select;
  logic [15:0] rx_word;
  logic idle_level = 1'b0;
  int n_errors = 0;
  int checked = 0;

  always #10 clock = ~clock;
  initial #3.3 forever #7.5 link_clock = ~link_clock;

  serial_queue_sequencer_control dut (.clock(clock), .resetn(resetn), .link_clock(link_clock),
    .bus_valid(bus_valid), .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ready(bus_ready), .bus_error(bus_error), .irq(irq),
    .transfer_enable(transfer_enable), .select(select), .serial_clock(serial_clock),
    .serial_out(serial_out), .serial_in(serial_in));

  serial_peripheral_model peer (.select(select), .idle_level(idle_level),
    .serial_clock(serial_clock), .serial_out(serial_out), .serial_in(serial_in),
    .rx_word(rx_word), .seen_select(seen_select));

  task end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check

  task hang(input string msg);
    n_errors++;
    $display("BAD %0t %s", $time, msg);
    end_sim();
  endtask : hang

  task xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
            output logic [15:0] q, output logic e, output int lat);
    int i;
    @(posedge clock);
    bus_valid <= 1'b1;
    bus_write <= w;
    bus_addr <= a;
    bus_wdata <= d;
    lat = 0;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      lat++;
      if (bus_ready === 1'b1) break;
    end
    if (i == 20) hang("no bus answer");
    q = bus_rdata;
    e = bus_error;
    bus_valid <= 1'b0;
  endtask : xfer

  task wr(input logic [11:0] a, input logic [15:0] d, input logic ee);
    logic [15:0] q;
    logic e;
    int l;
    xfer(1'b1, a, d, q, e, l);
    check(e === ee, "write error response");
  endtask : wr

  task rd(input logic [11:0] a, input logic [15:0] m, input logic [15:0] x);
    logic [15:0] q;
    logic e;
    int l;
    xfer(1'b0, a, 16'h0000, q, e, l);
    check((q & m) === x, "read value");
    check(l == ((a == DATA_PORT_OFFSET) ? 3 : 2), "read latency");
  endtask : rd

  task wait_flag(input logic [15:0] m);
    logic [15:0] q;
    logic e;
    int l, i;
    for (i = 0; i < 300; i++) begin
      xfer(1'b0, FLAGS_OFFSET, 16'h0000, q, e, l);
      if ((q & m) === m) break;
    end
    if (i == 300) hang("flag never set");
  endtask : wait_flag

  task wait_idle;
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clock);
      if (transfer_enable === 1'b0) break;
    end
    if (i == 400) hang("enable never cleared");
  endtask : wait_idle

  initial begin
    repeat (100000) @(posedge clock);
    hang("run too long");
  end

  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    rd(FLAGS_OFFSET, 16'hFFFF, FLAGS_RESET);
    rd(WRAP_OFFSET, 16'hFFFF, WRAP_RESET);
    rd(DELAY_ENABLE_OFFSET, 16'hFFFF, DELAY_ENABLE_RESET);
    check(select === 4'h0 && irq === 1'b0 && transfer_enable === 1'b0, "reset outputs");
    // ram access, crossing from the transmit into the receive section
    wr(ADDRESS_OFFSET, 16'h000F, 1'b0);
    wr(DATA_PORT_OFFSET, 16'h1111, 1'b0);
    wr(DATA_PORT_OFFSET, 16'h2222, 1'b0);
    rd(ADDRESS_OFFSET, 16'h003F, 16'h0011);
    wr(ADDRESS_OFFSET, 16'h0021, 1'b0);
    wr(DATA_PORT_OFFSET, 16'h06FF, 1'b0);
    wr(DATA_PORT_OFFSET, 16'h0600, 1'b0);
    wr(DATA_PORT_OFFSET, 16'h0900, 1'b0);
    wr(ADDRESS_OFFSET, 16'h0021, 1'b0);
    rd(DATA_PORT_OFFSET, 16'hFFFF, 16'h0600);
    wr(ADDRESS_OFFSET, 16'h0030, 1'b0);
    wr(DATA_PORT_OFFSET, 16'hFFFF, 1'b0);
    wr(ADDRESS_OFFSET, 16'h0030, 1'b0);
    rd(DATA_PORT_OFFSET, 16'hFFFF, 16'h0000);
    wr(ADDRESS_OFFSET, 16'h0001, 1'b0);
    wr(DATA_PORT_OFFSET, 16'hA5C3, 1'b0);
    wr(DATA_PORT_OFFSET, 16'h3CF0, 1'b0);
    wr(ADDRESS_OFFSET, 16'h000F, 1'b0);
    rd(DATA_PORT_OFFSET, 16'hFFFF, 16'h1111);
    wr(ADDRESS_OFFSET, 16'h0001, 1'b0);
    rd(DATA_PORT_OFFSET, 16'hFFFF, 16'hA5C3);
    rd(DATA_PORT_OFFSET, 16'hFFFF, 16'h3CF0);
    // one pass over entries 1..2 with active-low selects
    idle_level <= 1'b1;
    wr(WRAP_OFFSET, 16'h12F1, 1'b0);
    rd(WRAP_OFFSET, 16'h00F0, 16'h0000);
    wr(FLAGS_OFFSET, 16'h0100, 1'b0);
    wr(DELAY_ENABLE_OFFSET, 16'h8000, 1'b0);
    wait_flag(16'h0001);
    wait_idle();
    check(rx_word === 16'h3CF0 && seen_select === 4'h6, "last frame content");
    rd(WRAP_OFFSET, 16'h00F0, 16'h0020);
    check(select === 4'hF && irq === 1'b1, "idle selects and irq");
    wr(FLAGS_OFFSET, 16'h0000, 1'b0);
    check(irq === 1'b0, "masked finished irq");
    rd(FLAGS_OFFSET, 16'h000D, 16'h0001);
    wr(FLAGS_OFFSET, 16'h0001, 1'b0);
    rd(FLAGS_OFFSET, 16'h000D, 16'h0000);
    // wrap to the start pointer, then stop with halt
    idle_level <= 1'b0;
    wr(WRAP_OFFSET, 16'h6201, 1'b0);
    wr(DELAY_ENABLE_OFFSET, 16'h8000, 1'b0);
    wait_flag(16'h0001);
    wr(FLAGS_OFFSET, 16'h0001, 1'b0);
    wait_flag(16'h0001);
    check(transfer_enable === 1'b1, "wrap keeps running");
    wr(FLAGS_OFFSET, 16'h0001, 1'b0);
    wr(WRAP_OFFSET, 16'hE201, 1'b0);
    wait_idle();
    rd(FLAGS_OFFSET, 16'h0005, 16'h0001);
    check(select === 4'h0, "selects idle low");
    // refused accesses while entry 3 runs on its own in wrap mode
    wr(WRAP_OFFSET, 16'h6303, 1'b0);
    wr(FLAGS_OFFSET, 16'hC40D, 1'b0);
    wr(DELAY_ENABLE_OFFSET, 16'h8000, 1'b0);
    wr(ADDRESS_OFFSET, 16'h0023, 1'b0);
    wr(DATA_PORT_OFFSET, 16'h0F00, 1'b1);
    rd(ADDRESS_OFFSET, 16'h003F, 16'h0023);
    rd(FLAGS_OFFSET, 16'h0008, 16'h0008);
    wr(DELAY_ENABLE_OFFSET, 16'h0000, 1'b1);
    check(transfer_enable === 1'b1, "refused clear");
    wr(FLAGS_OFFSET, 16'h1408, 1'b0);
    wr(DELAY_ENABLE_OFFSET, 16'h0000, 1'b0);
    check(transfer_enable === 1'b1, "locked enable");
    rd(FLAGS_OFFSET, 16'h000C, 16'h0000);
    wr(FLAGS_OFFSET, 16'h0400, 1'b0);
    wr(DELAY_ENABLE_OFFSET, 16'h0000, 1'b0);
    rd(FLAGS_OFFSET, 16'h0004, 16'h0004);
    check(irq === 1'b1, "abort irq");
    wait_idle();
    wr(FLAGS_OFFSET, 16'h000D, 1'b0);
    check(irq === 1'b0, "flags cleared");
    end_sim();
  end
endmodule : serial_queue_sequencer_control_tb_top
